// [logic/spr_top.sv]
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module spr_top
	import spr_pkg::*;
#(
	parameter int NUM_SLOTS = 2,
	parameter int GOOD_DLY  = GOOD_DLY_CYC,
	parameter int OFF_LEAD  = OFF_LEAD_CYC,
	parameter int DEBOUNCE  = DEBOUNCE_CYC
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire spr_slot_in_type [NUM_SLOTS-1:0] slot_pins,
	output logic [NUM_SLOTS-1:0]             slot_good_n,
	output logic [NUM_SLOTS-1:0]             delayed_slot_good_n,
	output logic [NUM_SLOTS-1:0]             main_fault_n,
	output logic [NUM_SLOTS-1:0]             standby_fault_n,
	output logic [NUM_SLOTS-1:0]             main_rearm,
	output logic [NUM_SLOTS-1:0]             standby_rearm,
	output logic                             system_good_o,
	output logic                             system_good_oe,
	output logic                             fault_int_n_o,
	output logic                             fault_int_n_oe,
	output logic                             irq,
	input  wire logic [3:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [3:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	if (NUM_SLOTS < 1 || NUM_SLOTS * STATUS_STRIDE > 32) begin : g_bad
		$error("spr_top: slot count not supported");
	end

	spr_slot_in_type  [NUM_SLOTS-1:0] pin_s1_ff, pin_s2_ff;
	spr_slot_out_type [NUM_SLOTS-1:0] so;
	logic [NUM_SLOTS-1:0] low_cond, ovr, lost, dly_prev_ff, mf_prev_ff, sf_prev_ff, lost_prev_ff, fault_vec;
	logic [31:0]          event_ff, mask_ff, control_ff, status_w, event_set;
	logic [31:0]          rdata_ff;
	logic [3:0]           awaddr_ff;
	logic [31:0]          wdata_ff;
	logic [3:0]           wstrb_ff;
	logic                 aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
	logic [1:0]           bresp_ff, rresp_ff;
	logic                 sys_low_ff, int_ff, irq_ff;

	// Two-stage pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff <= {NUM_SLOTS{PIN_IDLE}};
			pin_s2_ff <= {NUM_SLOTS{PIN_IDLE}};
		end else begin
			pin_s1_ff <= slot_pins;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Per-slot sequencing and fault logic
	for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
		spr_slot #(
			.GOOD_DLY (GOOD_DLY),
			.OFF_LEAD (OFF_LEAD),
			.DEBOUNCE (DEBOUNCE)
		) u_slot (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.si       (pin_s2_ff[i]),
			.so       (so[i])
		);
		assign ovr[i]  = !pin_s2_ff[i].override_n;
		assign lost[i] = !so[i].latched;
		// Main rails low while requested
		wire main_low  = pin_s2_ff[i].main_power_request && !(pin_s2_ff[i].main12_ok && pin_s2_ff[i].main3_ok);
		// Standby rail low while requested
		wire stby_low  = pin_s2_ff[i].standby_power_request && !pin_s2_ff[i].standby_ok;
		assign low_cond[i] = so[i].latched && !ovr[i] && (main_low || stby_low);
		// Status word fields
		assign status_w[i*STATUS_STRIDE +: STATUS_STRIDE] = {2'b00, ovr[i], so[i].stby_fault,
			so[i].main_fault, so[i].dly_good, so[i].good, so[i].latched};
		// Event sources
		assign event_set[i*EVENT_STRIDE + EV_MAIN_FAULT] = so[i].main_fault && !mf_prev_ff[i];
		assign event_set[i*EVENT_STRIDE + EV_STBY_FAULT] = so[i].stby_fault && !sf_prev_ff[i];
		assign event_set[i*EVENT_STRIDE + EV_DLY_GOOD]   = so[i].dly_good && !dly_prev_ff[i];
		// Card removed: rising pin level, not debounced
		assign event_set[i*EVENT_STRIDE + EV_CARD_LOSS]  = pin_s2_ff[i].card_latched_n && !lost_prev_ff[i];
	end
	if (NUM_SLOTS * STATUS_STRIDE < 32) begin : g_stat_pad
		assign status_w[31:NUM_SLOTS*STATUS_STRIDE] = '0;
	end
	if (NUM_SLOTS * EVENT_STRIDE < 32) begin : g_ev_pad
		assign event_set[31:NUM_SLOTS*EVENT_STRIDE] = '0;
	end

	// Edge history for event detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_prev_ff  <= '0;
			mf_prev_ff   <= '0;
			sf_prev_ff   <= '0;
			lost_prev_ff <= '1;
		end else begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				dly_prev_ff[i]  <= so[i].dly_good;
				mf_prev_ff[i]   <= so[i].main_fault;
				sf_prev_ff[i]   <= so[i].stby_fault;
				lost_prev_ff[i] <= pin_s2_ff[i].card_latched_n;
			end
		end
	end

	// Pin outputs; override wins on the goods
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_good_n         <= '1;
			delayed_slot_good_n <= '1;
			main_fault_n        <= '1;
			standby_fault_n     <= '1;
			main_rearm          <= '0;
			standby_rearm       <= '0;
			sys_low_ff          <= 1'b0;
			int_ff              <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				slot_good_n[i]         <= !(so[i].good || ovr[i]);
				delayed_slot_good_n[i] <= !(so[i].dly_good || ovr[i]);
				main_fault_n[i]        <= !(so[i].main_fault && !ovr[i]);
				standby_fault_n[i]     <= !(so[i].stby_fault && !ovr[i]);
				main_rearm[i]          <= so[i].main_rearm;
				standby_rearm[i]       <= so[i].stby_rearm;
			end
			sys_low_ff <= |low_cond;
			int_ff     <= |(fault_vec & ~ovr);
		end
	end

	// Any slot fault, main or standby
	always_comb begin
		fault_vec = '0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			fault_vec[i] = so[i].main_fault || so[i].stby_fault;
		end
	end

	// Open-drain drive: low only when enabled
	assign system_good_o  = 1'b0;
	assign system_good_oe = sys_low_ff;
	assign fault_int_n_o  = 1'b0;
	assign fault_int_n_oe = int_ff;

	// Bus write decode
	wire       aw_take  = s_axi_awvalid && s_axi_awready;
	wire       w_take   = s_axi_wvalid && s_axi_wready;
	wire       wr_go    = aw_have_ff && w_have_ff && !bvalid_ff;
	wire       wr_event = wr_go && (awaddr_ff[3:2] == REG_EVENT[3:2]);
	wire       wr_mask  = wr_go && (awaddr_ff[3:2] == REG_MASK[3:2]);
	wire       wr_ctrl  = wr_go && (awaddr_ff[3:2] == REG_CONTROL[3:2]);
	wire       wr_ok    = wr_event || wr_mask || wr_ctrl;
	wire [31:0] wmask   = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire [31:0] w1c     = wr_event ? (wdata_ff & wmask) : 32'h0000_0000;
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// Write channel holding registers and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awaddr_ff  <= 4'h0;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_have_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Sticky events, mask and control; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_ff   <= 32'h0000_0000;
			mask_ff    <= MASK_RESET;
			control_ff <= CONTROL_RESET;
			irq_ff     <= 1'b0;
		end else begin
			event_ff <= (event_ff & ~w1c) | event_set;
			if (wr_mask) begin
				mask_ff <= (mask_ff & ~wmask) | (wdata_ff & wmask);
			end
			if (wr_ctrl) begin
				control_ff <= (control_ff & ~wmask) | (wdata_ff & wmask);
			end
			irq_ff <= control_ff[CTRL_IRQ_EN] && |(event_ff & mask_ff);
		end
	end
	assign irq = irq_ff;

	// Read decode
	wire [1:0]  rsel  = s_axi_araddr[3:2];
	wire        rd_ok = 1'b1;
	wire [31:0] rmux  = (rsel == REG_STATUS[3:2])  ? status_w :
	                    (rsel == REG_EVENT[3:2])   ? event_ff :
	                    (rsel == REG_MASK[3:2])    ? mask_ff  : control_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// Read data and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rmux;
			rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Checks
	chk_override_goods: assert property (@(posedge aclk) disable iff (!aresetn)
		ovr[0] |=> !slot_good_n[0] && !delayed_slot_good_n[0] && main_fault_n[0] && standby_fault_n[0])
		else $error("override did not force slot outputs");
	chk_int_on_fault: assert property (@(posedge aclk) disable iff (!aresetn)
		(so[0].main_fault || so[0].stby_fault) && !ovr[0] |=> fault_int_n_oe)
		else $error("fault without interrupt");
	chk_int_with_faults: assert property (@(posedge aclk) disable iff (!aresetn)
		fault_int_n_oe |-> !(&main_fault_n) || !(&standby_fault_n))
		else $error("interrupt without a fault output");
	chk_sysgood_undriven: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(low_cond == '0) |-> !system_good_oe) else $error("system good driven idle");
	chk_sysgood_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
		so[0].latched && !ovr[0] && pin_s2_ff[0].main_power_request && !pin_s2_ff[0].main12_ok
		|=> system_good_oe) else $error("main rail low not reported");
	chk_event_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		event_ff[(NUM_SLOTS-1)*EVENT_STRIDE + EV_MAIN_FAULT] && !wr_event
		|=> event_ff[(NUM_SLOTS-1)*EVENT_STRIDE + EV_MAIN_FAULT])
		else $error("event bit lost without clear");
	cov_sysgood_low: cover property (@(posedge aclk) disable iff (!aresetn) $rose(system_good_oe));
	cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
	cov_card_loss: cover property (@(posedge aclk) disable iff (!aresetn) event_set[EV_CARD_LOSS]);

	// Per-slot pin checks
	for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_chk
		chk_sysgood_main_low: assert property (@(posedge aclk) disable iff (!aresetn)
			so[i].latched && pin_s2_ff[i].override_n && pin_s2_ff[i].main_power_request
			&& !(pin_s2_ff[i].main12_ok && pin_s2_ff[i].main3_ok)
			|=> system_good_oe) else $error("main rail low not reported");
		chk_sysgood_stby_low: assert property (@(posedge aclk) disable iff (!aresetn)
			so[i].latched && pin_s2_ff[i].override_n && pin_s2_ff[i].standby_power_request
			&& !pin_s2_ff[i].standby_ok
			|=> system_good_oe) else $error("standby rail low not reported");
		chk_fault_pin_main: assert property (@(posedge aclk) disable iff (!aresetn)
			so[i].main_fault && !ovr[i] |=> !main_fault_n[i])
			else $error("main fault pin not asserted");
		chk_fault_pin_stby: assert property (@(posedge aclk) disable iff (!aresetn)
			so[i].stby_fault && !ovr[i] |=> !standby_fault_n[i])
			else $error("standby fault pin not asserted");
		chk_card_loss_pins: assert property (@(posedge aclk) disable iff (!aresetn)
			lost[i] && !ovr[i] ##1 !ovr[i] |=> slot_good_n[i] && delayed_slot_good_n[i])
			else $error("goods kept after card loss");
		chk_rearm_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
			main_rearm[i] |=> !main_rearm[i])
			else $error("re-arm pulse longer than one cycle");
	end

	// A taken answer is withdrawn at once
	chk_bresp_taken: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_rdata_taken: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");

endmodule // spr_top

// [logic/spr_pkg.sv]
package spr_pkg;

	// Timebase
	localparam int CLK_HZ          = 20_000_000;
	localparam int GOOD_DLY_MS     = 164;
	localparam int OFF_LEAD_MS     = 1;
	localparam int DEBOUNCE_MS     = 10;
	localparam int STBY_HOLD_NS    = 500;
	localparam int GOOD_DLY_CYC    = GOOD_DLY_MS * (CLK_HZ / 1000);
	localparam int OFF_LEAD_CYC    = OFF_LEAD_MS * (CLK_HZ / 1000);
	localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int STBY_HOLD_CYC   = (STBY_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Register map, byte offsets
	localparam logic [3:0] REG_STATUS  = 4'h0;
	localparam logic [3:0] REG_EVENT   = 4'h4;
	localparam logic [3:0] REG_MASK    = 4'h8;
	localparam logic [3:0] REG_CONTROL = 4'hC;

	// Field layout per slot, and the control register enable bit
	localparam int STATUS_STRIDE = 8;
	localparam int EVENT_STRIDE  = 4;
	localparam int EV_MAIN_FAULT = 0;
	localparam int EV_STBY_FAULT = 1;
	localparam int EV_DLY_GOOD   = 2;
	localparam int EV_CARD_LOSS  = 3;
	localparam int CTRL_IRQ_EN   = 0;

	// Reset values and bus response codes
	localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Pin levels of one slot
	typedef struct packed {
		logic main_power_request;
		logic standby_power_request;
		logic card_latched_n;
		logic override_n;
		logic main12_ok;
		logic main3_ok;
		logic standby_ok;
		logic main_trip;
		logic standby_trip;
	} spr_slot_in_type;

	// Idle pin levels held by the synchroniser in reset: no card, no override
	localparam spr_slot_in_type PIN_IDLE = 9'h060;

	// Slot state seen by the top
	typedef struct packed {
		logic latched;
		logic good;
		logic dly_good;
		logic main_fault;
		logic stby_fault;
		logic main_rearm;
		logic stby_rearm;
	} spr_slot_out_type;

endpackage

// [logic/spr_slot.sv]
`timescale 1ns/100ps
module spr_slot
	import spr_pkg::*;
#(
	parameter int GOOD_DLY = GOOD_DLY_CYC,
	parameter int OFF_LEAD = OFF_LEAD_CYC,
	parameter int DEBOUNCE = DEBOUNCE_CYC
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire spr_slot_in_type  si,
	output spr_slot_out_type      so
);
	localparam int DW = $clog2(GOOD_DLY + 1);
	localparam int OW = $clog2(OFF_LEAD + 1);
	localparam int BW = $clog2(DEBOUNCE + 1);
	localparam int HW = $clog2(STBY_HOLD_CYC + 1);

	if (GOOD_DLY < 2 || OFF_LEAD < 1 || DEBOUNCE < 1) begin : g_bad
		$error("spr_slot: delay counts too small");
	end

	logic [BW-1:0] deb_cnt_ff;
	logic [DW-1:0] dly_cnt_ff;
	logic [OW-1:0] off_cnt_ff;
	logic [HW-1:0] low_cnt_ff;
	logic          good_ff, dly_ff, main_req_d_ff, stby_req_d_ff;
	logic          main_fault_ff, stby_fault_ff, main_seen_ff, stby_seen_ff, stby_arm_ff;
	logic          main_rearm_ff, stby_rearm_ff;

	// Decode of slot conditions
	wire card_in    = !si.card_latched_n;
	wire latched    = card_in && (deb_cnt_ff == BW'(DEBOUNCE));
	wire main_fall  = main_req_d_ff && !si.main_power_request;
	wire stby_fall  = stby_req_d_ff && !si.standby_power_request;
	wire req_fall   = main_fall || stby_fall;
	wire faulted    = main_fault_ff || stby_fault_ff;
	wire main_rails = !si.main_power_request || (si.main12_ok && si.main3_ok);
	wire stby_rail  = !si.standby_power_request || si.standby_ok;
	wire any_req    = si.main_power_request || si.standby_power_request;
	wire want       = latched && any_req && main_rails && stby_rail && !faulted;
	wire stby_held  = stby_arm_ff && !si.standby_power_request && (low_cnt_ff == HW'(STBY_HOLD_CYC - 1));
	wire stby_ok_cl = stby_seen_ff || stby_held;
	wire main_ok_cl = main_seen_ff || main_fall;
	wire clr_main   = main_fault_ff && main_ok_cl && (!stby_fault_ff || stby_ok_cl);
	wire clr_stby   = stby_fault_ff && stby_ok_cl && (!main_fault_ff || main_ok_cl);
	wire ovr        = !si.override_n;

	// Card debounce; loss drops at once
	always_ff @(posedge aclk) begin
		if (!aresetn || !card_in) begin
			deb_cnt_ff <= '0;
		end else if (deb_cnt_ff != BW'(DEBOUNCE)) begin
			deb_cnt_ff <= deb_cnt_ff + 1'b1;
		end
	end

	// Slot good with 1 ms trailing hold
	always_ff @(posedge aclk) begin
		if (!aresetn || !latched) begin
			good_ff    <= 1'b0;
			off_cnt_ff <= '0;
		end else if (want) begin
			good_ff    <= 1'b1;
			off_cnt_ff <= '0;
		end else if (good_ff) begin
			off_cnt_ff <= off_cnt_ff + 1'b1;
			good_ff    <= (off_cnt_ff != OW'(OFF_LEAD));
		end
	end

	// Delayed good counter
	always_ff @(posedge aclk) begin
		if (!aresetn || !want || !good_ff || req_fall) begin
			dly_ff     <= 1'b0;
			dly_cnt_ff <= '0;
		end else if (!dly_ff) begin
			dly_cnt_ff <= dly_cnt_ff + 1'b1;
			dly_ff     <= (dly_cnt_ff == DW'(GOOD_DLY - 1));
		end
	end

	// Request edge history and standby low timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_req_d_ff <= 1'b0;
			stby_req_d_ff <= 1'b0;
			low_cnt_ff    <= '0;
			stby_arm_ff   <= 1'b0;
		end else begin
			main_req_d_ff <= si.main_power_request;
			stby_req_d_ff <= si.standby_power_request;
			if (si.standby_power_request) begin
				low_cnt_ff  <= '0;
				stby_arm_ff <= 1'b1;
			end else if (stby_held) begin
				stby_arm_ff <= 1'b0;
			end else if (stby_arm_ff) begin
				low_cnt_ff  <= low_cnt_ff + 1'b1;
			end
		end
	end

	// Fault flags; a trip wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_fault_ff <= 1'b0;
			stby_fault_ff <= 1'b0;
			main_seen_ff  <= 1'b0;
			stby_seen_ff  <= 1'b0;
			main_rearm_ff <= 1'b0;
			stby_rearm_ff <= 1'b0;
		end else begin
			main_fault_ff <= (si.main_trip && !ovr) || (main_fault_ff && !clr_main);
			stby_fault_ff <= (si.standby_trip && !ovr) || (stby_fault_ff && !clr_stby);
			main_seen_ff  <= main_fault_ff && !clr_main && main_ok_cl;
			stby_seen_ff  <= stby_fault_ff && !clr_stby && stby_ok_cl;
			main_rearm_ff <= clr_main;
			stby_rearm_ff <= clr_stby;
		end
	end

	assign so = '{latched: latched, good: good_ff, dly_good: dly_ff, main_fault: main_fault_ff,
		stby_fault: stby_fault_ff, main_rearm: main_rearm_ff, stby_rearm: stby_rearm_ff};

	// Checks
	chk_dly_needs_good: assert property (@(posedge aclk) disable iff (!aresetn)
		dly_ff |-> good_ff) else $error("delayed good without slot good");
	chk_dly_req_fall: assert property (@(posedge aclk) disable iff (!aresetn)
		req_fall |=> !dly_ff) else $error("delayed good kept after request fall");
	chk_good_outlasts_dly: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(good_ff) && $past(latched) |-> $past(!dly_ff, 1) && $past(!want, 1))
		else $error("slot good dropped before delayed good");
	chk_card_loss_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!card_in |=> !good_ff && !dly_ff) else $error("outputs kept after card loss");
	chk_stby_clear_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(stby_fault_ff) |-> $past(!si.standby_power_request, 1) && $past(!si.standby_power_request, 9))
		else $error("standby fault cleared without 0.5 us low");
	chk_both_faults_pair: assert property (@(posedge aclk) disable iff (!aresetn)
		main_fault_ff && stby_fault_ff && !main_fall && !main_seen_ff |=> stby_fault_ff)
		else $error("standby fault released before main edge");
	cov_dly_good: cover property (@(posedge aclk) disable iff (!aresetn) $rose(dly_ff));
	cov_double_fault_clear: cover property (@(posedge aclk) disable iff (!aresetn)
		$fell(main_fault_ff) && $fell(stby_fault_ff));

endmodule // spr_slot

// [logic/unused_guard.sv]
`timescale 1ns/100ps

// [bench/spr_host_model.sv]
`timescale 1ns/100ps
// Hot-plug controller side: holds the request levels and runs the fault clearing drop
module spr_host_model #(
	parameter int HOLD = 12
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] want_main,
	input  wire logic [1:0] want_stby,
	input  wire logic [1:0] clr,
	output logic      [1:0] main_req,
	output logic      [1:0] stby_req
);
	int hold_ff [2];

	// A clear drops both requests together for HOLD cycles, 600 ns, above the 500 ns minimum
	always @(posedge aclk) begin
		for (int i = 0; i < 2; i++) begin
			if (!aresetn) hold_ff[i] <= 0;
			else if (clr[i]) hold_ff[i] <= HOLD;
			else if (hold_ff[i] > 0) hold_ff[i] <= hold_ff[i] - 1;
		end
	end

	// Requests follow what the bench wants except while a clear is running
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			main_req[i] = want_main[i] && (hold_ff[i] == 0);
			stby_req[i] = want_stby[i] && (hold_ff[i] == 0);
		end
	end
endmodule // spr_host_model

// [bench/spr_top_test.sv]
`timescale 1ns/100ps
module spr_top_test;
	import spr_pkg::*;
	localparam int GD = 40;
	localparam int OL = 8;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [1:0] card_n = 2'h0, ovr_n = 2'h3, m12 = 2'h3, m3 = 2'h3, sok = 2'h3, mtrip = 2'h0, strip = 2'h0;
	logic [1:0] wm = 2'h0, ws = 2'h0, clr = 2'h0, mreq, sreq, sg_n, dg_n, mf_n, sf_n, mra, sra;
	logic sys_oe, int_oe, irq, awr, wr_r, bv, arr, rv, sgo, fio;
	logic [3:0] awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0000_0000, rd_d, rdat;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [1:0] bresp, rresp;
	spr_slot_in_type [1:0] pins;
	int n_mismatch = 0, num_checks = 0, cyc = 0, n, n_mra = 0, n_sra = 0;

	always #25 aclk = ~aclk;
	always_comb for (int i = 0; i < 2; i++) pins[i] = {mreq[i], sreq[i], card_n[i], ovr_n[i], m12[i], m3[i], sok[i], mtrip[i], strip[i]};

	spr_host_model u_host (.aclk(aclk), .aresetn(aresetn), .want_main(wm), .want_stby(ws), .clr(clr),
		.main_req(mreq), .stby_req(sreq));
	spr_top #(.GOOD_DLY(GD), .OFF_LEAD(OL), .DEBOUNCE(16)) u_dut (.aclk(aclk), .aresetn(aresetn), .slot_pins(pins),
		.slot_good_n(sg_n), .delayed_slot_good_n(dg_n), .main_fault_n(mf_n), .standby_fault_n(sf_n),
		.main_rearm(mra), .standby_rearm(sra), .system_good_o(sgo), .system_good_oe(sys_oe), .fault_int_n_o(fio),
		.fault_int_n_oe(int_oe), .irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic ticks(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// Write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!(bv === 1'b1));
		check("bresp", bresp, er);
		br <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [3:0] a);
		ara <= a; arv <= 1'b1; rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (!(rv === 1'b1));
		rd_d = rdat;
		check("rresp", rresp, RESP_OKAY);
		rr <= 1'b0;
		@(posedge aclk);
	endtask

	// Reference for the system good pull-down
	function automatic logic exp_pull();
		for (int i = 0; i < 2; i++)
			if (!card_n[i] && ovr_n[i] && ((mreq[i] && !(m12[i] && m3[i])) || (sreq[i] && !sok[i]))) return 1'b1;
		return 1'b0;
	endfunction

	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (mra[1] === 1'b1) n_mra++;
		if (sra[1] === 1'b1) n_sra++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		void'($urandom(34952));
		ticks(3);
		aresetn <= 1'b1;
		check("goods_n", {sg_n, dg_n}, 4'hf);
		check("oe", {sys_oe, int_oe, irq}, 3'h0);
		check("od_levels", {sgo, fio}, 2'h0);
		ticks(30);
		// Slot 0 power up, delay, then power down with lead
		wm[0] <= 1'b1;
		for (n = 0; n < 100 && sg_n[0] !== 1'b0; n++) @(posedge aclk);
		for (n = 0; n < 200 && dg_n[0] !== 1'b0; n++) @(posedge aclk);
		check("dly_good", (n >= GD - 2 && n <= GD + 2), 1);
		wm[0] <= 1'b0;
		for (n = 0; n < 100 && dg_n[0] !== 1'b1; n++) @(posedge aclk);
		check("good_held", sg_n[0], 1'b0);
		for (n = 0; n < 100 && sg_n[0] !== 1'b1; n++) @(posedge aclk);
		check("off_lead", (n >= OL - 2 && n <= OL + 2), 1);
		// Random rails, requests and overrides against the pull-down model
		for (int k = 0; k < 24; k++) begin
			{wm, ws, ovr_n, m12, m3, sok} <= 12'($urandom());
			ticks(12);
			check("sys_oe", sys_oe, exp_pull());
			check("int_oe", int_oe, 1'b0);
			for (int i = 0; i < 2; i++) if (!ovr_n[i]) check("ovr_good", {sg_n[i], dg_n[i]}, 2'h0);
		end
		{wm, ovr_n, m12, m3, sok} <= 10'h3ff;
		ws <= 2'h3;
		ticks(30);
		// Both rails of slot 1 trip
		{mtrip[1], strip[1]} <= 2'h3;
		ticks(4);
		{mtrip[1], strip[1]} <= 2'h0;
		ticks(8);
		check("int", int_oe, 1'b1);
		check("faults", {mf_n, sf_n}, 4'h5);
		axi_rd(REG_EVENT);
		check("event", rd_d[5:4], 2'h3);
		check("irq_masked", irq, 1'b0);
		axi_wr(REG_MASK, 32'h0000_0010, RESP_OKAY);
		ticks(3);
		check("irq", irq, 1'b1);
		// Main request edge alone leaves a double fault latched
		wm[1] <= 1'b0;
		ticks(3);
		wm[1] <= 1'b1;
		ticks(15);
		check("dbl_fault", {mf_n[1], sf_n[1], int_oe}, 3'h1);
		check("no_rearm", n_mra + n_sra, 0);
		clr[1] <= 1'b1;
		ticks(1);
		clr[1] <= 1'b0;
		ticks(25);
		check("cleared", {mf_n[1], sf_n[1], int_oe}, 3'h6);
		check("rearm", {n_mra[7:0], n_sra[7:0]}, 16'h0101);
		axi_wr(REG_EVENT, 32'h0000_0030, RESP_OKAY);
		ticks(3);
		check("irq_clr", irq, 1'b0);
		axi_wr(REG_STATUS, 32'h0000_ffff, RESP_SLVERR);
		axi_rd(REG_CONTROL);
		check("control", rd_d, CONTROL_RESET);
		axi_rd(REG_MASK);
		check("mask", rd_d, 32'h0000_0010);
		// Pulling slot 0's card drops its goods at once
		check("pre_loss", sg_n[0], 1'b0);
		card_n[0] <= 1'b1;
		ticks(6);
		check("card_loss", {sg_n[0], dg_n[0]}, 2'h3);
		axi_rd(REG_STATUS);
		check("latched", {rd_d[STATUS_STRIDE], rd_d[0]}, 2'h2);
		axi_rd(REG_EVENT);
		check("loss_event", rd_d[EV_CARD_LOSS], 1'b1);
		conclude();
	end
endmodule // spr_top_test
